// >>> rtl/park_seq_pkg.sv
// package for the power-up and mirror-park sequencer
// assumes a single 50 MHz clock domain and no software registers
// Function
// - flash pins and gpio float during reset
// - light selects and mirror enable low in reset
// - wait pll lock, then load flash config
// - after reset drive status line high
// - drive status line low when init done
// - fast park request low starts fast park
// - power request drop starts normal park
// - normal park finishes within 20 ms
package park_seq_pkg;
  localparam int CLK_MHZ = 50; // clock rate
  localparam int FAST_PARK_US = 32; // fast park window
  localparam int NORMAL_PARK_MS = 20; // normal park limit
  // fast park must finish inside its window: round down
  localparam int FAST_PARK_CYC = FAST_PARK_US * CLK_MHZ;
  localparam int NORMAL_PARK_CYC = NORMAL_PARK_MS * 1000 * CLK_MHZ;
  localparam int GPIO_W = 20; // gpio 19 down to 0
  localparam int CNT_W = 20; // park counter is CNT_W+2 bits wide
  // sequencer states
  typedef enum logic [2:0] {
    ST_PLL_WAIT = 3'b000,
    ST_FLASH_LOAD = 3'b001,
    ST_RUN = 3'b010,
    ST_NORMAL_PARK = 3'b011,
    ST_FAST_PARK = 3'b100,
    ST_PARKED = 3'b101
  } seq_state_e;
  // grouped mirror / light outputs
  typedef struct packed {
    logic light_source_select_0;
    logic light_source_select_1;
    logic mirror_array_enable_reset_n;
  } drive_s;
endpackage : park_seq_pkg

// >>> rtl/display_ctrl_powerup_park_seq.sv
// reset, boot order and mirror park sequencer of a display controller
// assumes pll lock and flash load done arrive as clk_in-synchronous levels
`timescale 1ns/10ps
module display_ctrl_powerup_park_seq
  import park_seq_pkg::*;
#(
  parameter int unsigned NORMAL_PARK_CYCLES = NORMAL_PARK_CYC
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic fast_mirror_park_request_n_in,
  input wire logic projector_power_request_in,
  input wire logic pll_locked_in,
  input wire logic flash_load_done_in,
  input wire logic park_done_in,
  output logic flash_load_start_out,
  output logic init_status_irq_out,
  output logic normal_park_active_out,
  output logic fast_park_active_out,
  output logic park_timeout_out,
  output logic pins_enable_out,
  output logic flash_serial_clock_oe_b_out,
  output logic flash_serial_data_out_oe_b_out,
  output logic flash_select_0_n_oe_b_out,
  output logic flash_select_1_n_oe_b_out,
  output logic [GPIO_W-1:0] gpio_oe_b_out,
  output drive_s drive_out
);
  // reset synchroniser: assert async, release on clock
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end
  // two-stage synchroniser for fast park request
  logic park_meta_n;
  logic park_sync_n;
  always_ff @(posedge clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      park_meta_n <= 1'b1;
      park_sync_n <= 1'b1;
    end else if (ce_in) begin
      park_meta_n <= fast_mirror_park_request_n_in;
      park_sync_n <= park_meta_n;
    end
  end
  // sequencer state and park counter
  seq_state_e state, next_state;
  logic [CNT_W+1:0] cnt, next_cnt; // holds up to 20 ms
  logic irq, next_irq;
  logic timeout, next_timeout;
  // next-state logic
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_irq = irq;
    next_timeout = timeout;
    // fast park outranks everything in every state but fast park and parked, boot included
    if (!park_sync_n && state != ST_FAST_PARK && state != ST_PARKED) begin
      next_state = ST_FAST_PARK;
      next_cnt = '0;
    end else begin
      case (state)
        ST_PLL_WAIT: begin
          if (pll_locked_in) next_state = ST_FLASH_LOAD;
        end
        ST_FLASH_LOAD: begin
          if (flash_load_done_in) begin
            next_state = ST_RUN;
            next_irq = 1'b0;
          end
        end
        ST_RUN: begin
          if (!projector_power_request_in) begin
            next_state = ST_NORMAL_PARK;
            next_cnt = '0;
          end
        end
        ST_NORMAL_PARK: begin
          // finish on park done or force at the 20 ms limit
          if (park_done_in) begin
            next_state = ST_PARKED;
          end else if (cnt >= (CNT_W+2)'(NORMAL_PARK_CYCLES - 1)) begin
            next_state = ST_PARKED;
            next_timeout = 1'b1;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        ST_FAST_PARK: begin
          // fast park is a fixed-length window
          if (cnt >= (CNT_W+2)'(FAST_PARK_CYC - 1)) begin
            next_state = ST_PARKED;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
        ST_PARKED: begin
          // leave on power request high once the fast park request is released, after either park
          if (projector_power_request_in && park_sync_n) begin
            next_state = ST_RUN;
            next_timeout = 1'b0;
          end
        end
        default: next_state = ST_PLL_WAIT;
      endcase
    end
  end
  // state registers; reset sets irq high
  always_ff @(posedge clk_in or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= ST_PLL_WAIT;
      cnt <= '0;
      irq <= 1'b1;
      timeout <= 1'b0;
    end else if (ce_in) begin
      state <= next_state;
      cnt <= next_cnt;
      irq <= next_irq;
      timeout <= next_timeout;
    end
  end
  // outputs: pins float and drives low while reset holds
  logic running;
  assign running = (state == ST_RUN);
  assign pins_enable_out = rst_sync_b;
  assign flash_serial_clock_oe_b_out = ~rst_sync_b;
  assign flash_serial_data_out_oe_b_out = ~rst_sync_b;
  assign flash_select_0_n_oe_b_out = ~rst_sync_b;
  assign flash_select_1_n_oe_b_out = ~rst_sync_b;
  assign gpio_oe_b_out = {GPIO_W{~rst_sync_b}};
  // one driver for the whole struct keeps its members single-sourced
  assign drive_out = {3{running}};
  assign flash_load_start_out = (state == ST_FLASH_LOAD);
  assign init_status_irq_out = irq;
  assign normal_park_active_out = (state == ST_NORMAL_PARK);
  assign fast_park_active_out = (state == ST_FAST_PARK);
  assign park_timeout_out = timeout;

  // flash load never begins before pll lock
  property p_flash_after_lock;
    @(posedge clk_in) disable iff (!rst_sync_b)
      $rose(flash_load_start_out) |-> $past(pll_locked_in);
  endproperty
  a_flash_after_lock: assert property (p_flash_after_lock)
    else $error("flash load started without pll lock");

  // status high from reset until init done
  property p_irq_high_boot;
    @(posedge clk_in) disable iff (!rst_sync_b)
      (state == ST_PLL_WAIT || state == ST_FLASH_LOAD) |-> irq;
  endproperty
  a_irq_high_boot: assert property (p_irq_high_boot)
    else $error("status line low during init");

  // status drops with entry to run
  property p_irq_low_done;
    @(posedge clk_in) disable iff (!rst_sync_b)
      (ce_in && state == ST_FLASH_LOAD && flash_load_done_in
       && park_sync_n) |=> !irq && running;
  endproperty
  a_irq_low_done: assert property (p_irq_low_done)
    else $error("status line not low after init");

  // fast park entered the cycle after the synchronised request
  property p_fast_park;
    @(posedge clk_in) disable iff (!rst_sync_b)
      (ce_in && !park_sync_n && running) |=> fast_park_active_out;
  endproperty
  a_fast_park: assert property (p_fast_park)
    else $error("fast park not entered");

  // normal park on power request drop
  property p_normal_park;
    @(posedge clk_in) disable iff (!rst_sync_b)
      (ce_in && running && park_sync_n && !projector_power_request_in)
        |=> normal_park_active_out;
  endproperty
  a_normal_park: assert property (p_normal_park)
    else $error("normal park not started");

  // normal park counter never exceeds limit
  property p_park_limit;
    @(posedge clk_in) disable iff (!rst_sync_b)
      normal_park_active_out |-> cnt < (CNT_W+2)'(NORMAL_PARK_CYCLES);
  endproperty
  a_park_limit: assert property (p_park_limit)
    else $error("normal park over 20 ms");

  // mirror enable and light select 0 low whenever not running
  property p_drive_low;
    @(posedge clk_in) disable iff (!rst_sync_b)
      !running |-> !drive_out.mirror_array_enable_reset_n
        && !drive_out.light_source_select_0;
  endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("mirror drive high outside run");

  // oe low once out of reset
  property p_pins_live;
    @(posedge clk_in) disable iff (!rst_sync_b)
      rst_sync_b |-> !flash_serial_clock_oe_b_out && gpio_oe_b_out == '0;
  endproperty
  a_pins_live: assert property (p_pins_live)
    else $error("pins floating after reset");

  // pins float and drives stay low while the reset input is low
  // no disable here: this one must watch the reset itself
  property p_reset_float;
    @(posedge clk_in)
      (!rst_b_in && !rst_sync_b) |-> flash_serial_clock_oe_b_out
        && flash_serial_data_out_oe_b_out && flash_select_0_n_oe_b_out
        && flash_select_1_n_oe_b_out && gpio_oe_b_out == '1
        && drive_out == '0;
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("pins driven during reset");

  // last count of a normal park forces the exit and the flag
  property p_park_timeout;
    @(posedge clk_in) disable iff (!rst_sync_b)
      (ce_in && normal_park_active_out && park_sync_n && !park_done_in
       && cnt == (CNT_W+2)'(NORMAL_PARK_CYCLES - 1))
        |=> park_timeout_out && !normal_park_active_out;
  endproperty
  a_park_timeout: assert property (p_park_timeout)
    else $error("normal park did not stop at its limit");
endmodule : display_ctrl_powerup_park_seq

// >>> verification/park_seq_partner.sv
// model of the pll reference and the configuration flash
// assumes the bench drives reset and power inputs itself
`timescale 1ns/10ps
module park_seq_partner (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic flash_load_start_in,
  input wire logic slow_in,
  output logic pll_locked_out,
  output logic flash_load_done_out
);
  int cnt; // cycles since reset release
  int lim; // lock delay, long when slow
  assign lim = slow_in ? 40 : 3;
  // lock is lost in reset; flash answers only once asked
  always @(negedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 0;
      pll_locked_out <= 1'b0;
      flash_load_done_out <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      pll_locked_out <= (cnt >= lim);
      flash_load_done_out <= flash_load_start_in && (cnt >= 2 * lim);
    end
  end
endmodule : park_seq_partner

// >>> verification/tb_top.sv
// self-checking bench for the power-up and park sequencer
// assumes the partner model answers pll lock and flash load
`timescale 1ns/10ps
module tb_top;
  import park_seq_pkg::*;
  logic clk_in = 0, rst_b_in = 0, ce_in = 1, park_n = 1, pwr = 0;
  logic slow = 1, park_done = 0, pll, fdone, start, irq, npa, fpa, tmo;
  logic pen, c_oe, d_oe, s0_oe, s1_oe;
  logic [GPIO_W-1:0] g_oe;
  drive_s drv;
  int err_total = 0, n_tests = 0;
  display_ctrl_powerup_park_seq #(.NORMAL_PARK_CYCLES(50)) dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in),
    .fast_mirror_park_request_n_in(park_n),
    .projector_power_request_in(pwr), .pll_locked_in(pll),
    .flash_load_done_in(fdone), .park_done_in(park_done),
    .flash_load_start_out(start), .init_status_irq_out(irq),
    .normal_park_active_out(npa), .fast_park_active_out(fpa),
    .park_timeout_out(tmo), .pins_enable_out(pen),
    .flash_serial_clock_oe_b_out(c_oe),
    .flash_serial_data_out_oe_b_out(d_oe),
    .flash_select_0_n_oe_b_out(s0_oe),
    .flash_select_1_n_oe_b_out(s1_oe), .gpio_oe_b_out(g_oe),
    .drive_out(drv));
  park_seq_partner mdl (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .flash_load_start_in(start), .slow_in(slow),
    .pll_locked_out(pll), .flash_load_done_out(fdone));
  // 50 mhz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  // one compare for every kind of result
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // outputs held while reset is low
  task t_hold();
    chk({c_oe, d_oe, s0_oe, s1_oe, g_oe}, 24'hFFFFFF);
    chk(drv, 24'h0);
    chk(irq, 24'h1);
    $display("test hold done");
  endtask : t_hold
  // release, then lock before load, status low at the end
  task t_boot();
    int i;
    @(negedge clk_in) rst_b_in = 1;
    @(negedge clk_in);
    chk(pen, 24'h0);
    repeat (2) @(negedge clk_in);
    chk(pen, 24'h1);
    chk(irq, 24'h1);
    for (i = 0; i < 300 && irq !== 1'b0; i++) begin
      @(negedge clk_in);
      chk(start & ~pll, 24'h0);
    end
    chk(irq, 24'h0);
    chk(drv, 24'h7);
    chk({c_oe, d_oe, s0_oe, s1_oe, g_oe}, 24'h0);
    $display("test boot done");
  endtask : t_boot
  // power request drop with no park answer runs to the limit
  task t_normal();
    @(negedge clk_in) pwr = 0;
    @(negedge clk_in);
    chk(npa, 24'h1);
    // 50-cycle limit: last park cycle, then parked with the flag
    repeat (49) @(negedge clk_in);
    chk({tmo, npa}, 24'h1);
    @(negedge clk_in);
    chk({tmo, npa, drv}, 24'h10);
    $display("test normal park done");
  endtask : t_normal
  // park answer ends a normal park early; ce low freezes it
  task t_done();
    @(negedge clk_in) pwr = 1;
    @(negedge clk_in);
    chk({irq, tmo, drv}, 24'h7);
    pwr = 0;
    @(negedge clk_in);
    chk(npa, 24'h1);
    ce_in = 0;
    park_done = 1;
    // longer than the limit: only a frozen counter survives it
    repeat (60) @(negedge clk_in);
    chk({npa, tmo}, 24'h2);
    ce_in = 1;
    @(negedge clk_in);
    chk({tmo, npa, drv}, 24'h0);
    park_done = 0;
    $display("test park answer done");
  endtask : t_done
  // back to run, then a fast park for its fixed window
  task t_fast();
    @(negedge clk_in) pwr = 1;
    repeat (3) @(negedge clk_in);
    chk(drv, 24'h7);
    park_n = 0;
    @(negedge clk_in);
    chk(fpa, 24'h0);
    repeat (3) @(negedge clk_in);
    chk({fpa, drv}, 24'h8);
    // window is exactly 1600 cycles: last cycle, then parked
    repeat (1598) @(negedge clk_in);
    chk(fpa, 24'h1);
    @(negedge clk_in);
    chk(fpa, 24'h0);
    park_n = 1;
    $display("test fast park done");
  endtask : t_fast
  // reset while parked acts at once, then a prompt reboot
  task t_midreset();
    @(negedge clk_in) rst_b_in = 0;
    #1 t_hold();
    slow = 0;
    t_boot();
    $display("test mid reset done");
  endtask : t_midreset
  // the only place the run ends
  task wrap_up();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  // main sequence: reset held low 5 cycles, park high
  initial begin
    repeat (4) @(negedge clk_in);
    t_hold();
    pwr = 1;
    t_boot();
    t_normal();
    t_done();
    t_fast();
    t_midreset();
    wrap_up();
  end
  // hang guard well past the expected run of under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    wrap_up();
  end
endmodule : tb_top
